// File: hdl/latch_src_consts.svh
// Constants for the latch input source selection block.
`ifndef LATCH_SRC_CONSTS_SVH
`define LATCH_SRC_CONSTS_SVH

// ------------------------------------------------------------------------
// Register map (word addresses)
// ------------------------------------------------------------------------
`define SRC_ADDR_W          2
`define SRC_CTRL_OFFSET     2'h0
`define SRC_DIV_OFFSET      2'h1
`define SRC_STATUS_OFFSET   2'h2
`define SRC_CTRL_RESET      8'h00
`define SRC_DIV_RESET       3'h0

// ------------------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------------------
`define SRC_BIT_PIN_SET     7
`define SRC_BIT_CLK_SET     6
`define SRC_BIT_CMP2_SET    5
`define SRC_BIT_CMP1_SET    4
`define SRC_BIT_PIN_RST     3
`define SRC_BIT_CLK_RST     2
`define SRC_BIT_CMP2_RST    1
`define SRC_BIT_CMP1_RST    0

// ------------------------------------------------------------------------
// Divider: period is 4 shifted left by the select code
// ------------------------------------------------------------------------
`define SRC_DIV_BASE_LOG2   2
`define SRC_DIV_CNT_W       9
`define SRC_UNMAPPED_READ   32'h0000_0000

`endif

// File: hdl/latch_src_pkg.sv
// Types shared by the latch input source selection block.
`default_nettype none
package latch_src_pkg;
   typedef struct packed {
      logic [1:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } av_rsp_t;

   typedef struct packed {
      logic pin;
      logic cmp_one;
      logic cmp_two;
   } src_in_t;

   typedef struct packed {
      logic set_req;
      logic reset_req;
   } latch_drive_t;
endpackage : latch_src_pkg
`default_nettype wire

// File: hdl/latch_pulse_divider.sv
// Periodic one-cycle pulse generator for the latch clock source.
`include "latch_src_consts.svh"
`default_nettype none
module latch_pulse_divider (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Period select
   input  wire logic [2:0] latch_pulse_divider_select,
   // Pulse out
   output logic            pulse
);
   typedef struct packed {
      logic [`SRC_DIV_CNT_W-1:0] count;
      logic                      pulse;
   } div_state_t;

   div_state_t state;
   div_state_t next_state;
   logic [`SRC_DIV_CNT_W-1:0] last;

   // Terminal count is period minus one; period is 4 << select.
   assign last = `SRC_DIV_CNT_W'((`SRC_DIV_CNT_W'(1)
                  << (`SRC_DIV_BASE_LOG2 + 32'(latch_pulse_divider_select)))
                  - `SRC_DIV_CNT_W'(1));

   always_comb begin
      next_state = state;
      next_state.pulse = 1'b0;
      if (state.count >= last) begin
         next_state.count = '0;
         next_state.pulse = 1'b1;
      end else begin
         next_state.count = state.count + `SRC_DIV_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pulse = state.pulse;
endmodule : latch_pulse_divider
`default_nettype wire

// File: hdl/latch_input_select.sv
// Source selection for the set and reset inputs of a set/reset latch.
`include "latch_src_consts.svh"
`default_nettype none

module latch_input_select (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Avalon-MM slave
   input  wire latch_src_pkg::av_req_t av_req,
   output latch_src_pkg::av_rsp_t      av_rsp,
   // Asynchronous sources
   input  wire latch_src_pkg::src_in_t src_in,
   // Drive toward the latch core
   output latch_src_pkg::latch_drive_t latch_drive
);
   import latch_src_pkg::*;

   typedef struct packed {
      logic [7:0]  control;
      logic [2:0]  divider;
      src_in_t     sync1;
      src_in_t     sync2;
      logic        ack;
      logic [31:0] readdata;
      latch_drive_t drive;
   } sel_state_t;

   sel_state_t state;
   sel_state_t next_state;
   logic       clk_pulse;

   // ---------------------------------------------------------------------
   // Divided clock source
   // ---------------------------------------------------------------------
   latch_pulse_divider u_div (
      .clk                        (clk),
      .rst_n                      (rst_n),
      .latch_pulse_divider_select (state.divider),
      .pulse                      (clk_pulse)
   );

   function automatic logic [31:0] read_mux(input logic [1:0] addr,
                                           input sel_state_t s);
      logic [31:0] v;
      v = `SRC_UNMAPPED_READ;
      unique case (addr)
         `SRC_CTRL_OFFSET:   v = {24'h00_0000, s.control};
         `SRC_DIV_OFFSET:    v = {29'h0000_0000, s.divider};
         `SRC_STATUS_OFFSET: v = {27'h000_0000, s.sync2, s.drive};
         default:            v = `SRC_UNMAPPED_READ;
      endcase
      return v;
   endfunction : read_mux

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      logic [7:0] c;
      logic       req;
      c = state.control;
      next_state = state;
      next_state.sync1 = src_in;
      next_state.sync2 = state.sync1;
      req = av_req.read | av_req.write;
      // Each access is answered one cycle after it is seen.
      next_state.ack = req & ~state.ack;
      if (req && !state.ack) begin
         if (av_req.write && av_req.byteenable[0]) begin
            if (av_req.address == `SRC_CTRL_OFFSET) begin
               next_state.control = av_req.writedata[7:0];
            end
            if (av_req.address == `SRC_DIV_OFFSET) begin
               next_state.divider = av_req.writedata[2:0];
            end
         end
         next_state.readdata = read_mux(av_req.address, state);
      end
      // Same-source set and reset together is left to software.
      next_state.drive.set_req =
           (c[`SRC_BIT_PIN_SET]  & state.sync2.pin)
         | (c[`SRC_BIT_CLK_SET]  & clk_pulse)
         | (c[`SRC_BIT_CMP2_SET] & state.sync2.cmp_two)
         | (c[`SRC_BIT_CMP1_SET] & state.sync2.cmp_one);
      next_state.drive.reset_req =
           (c[`SRC_BIT_PIN_RST]  & state.sync2.pin)
         | (c[`SRC_BIT_CLK_RST]  & clk_pulse)
         | (c[`SRC_BIT_CMP2_RST] & state.sync2.cmp_two)
         | (c[`SRC_BIT_CMP1_RST] & state.sync2.cmp_one);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= '0;
         state.control <= `SRC_CTRL_RESET;
         state.divider <= `SRC_DIV_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign av_rsp.waitrequest = (av_req.read | av_req.write) & ~state.ack;
   assign av_rsp.readdata    = state.readdata;
   assign latch_drive        = state.drive;
endmodule : latch_input_select
`default_nettype wire

// File: tb/latch_src_partner.sv
// Far-side model of the input pin and the two comparator outputs.
`default_nettype none
module latch_src_partner (
   // Clock and commanded levels
   input  wire logic            clk,
   input  wire logic [2:0]      lvl,
   // Source levels
   output var latch_src_pkg::src_in_t src
);
   import latch_src_pkg::*;
   initial src = '0;
   // Levels move on the falling edge, away from the sampling edge.
   always @(negedge clk) src <= lvl;
endmodule : latch_src_partner
`default_nettype wire

// File: tb/latch_src_asserts.sv
// Assertions on the ports of the latch input select block.
`default_nettype none
module latch_src_asserts (
   input wire logic                         clk,
   input wire logic                         rst_n,
   input wire latch_src_pkg::av_req_t       av_req,
   input wire latch_src_pkg::av_rsp_t       av_rsp,
   input wire latch_src_pkg::src_in_t       src_in,
   input wire latch_src_pkg::latch_drive_t  latch_drive
);
   import latch_src_pkg::*;
   logic [7:0] c;
   // Shadow of the control register, taken from accepted writes.
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) c <= 8'h00;
      else if (av_req.write && !av_rsp.waitrequest && av_req.address == 2'h0
               && av_req.byteenable[0]) c <= av_req.writedata[7:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_pin; src_in.pin[*4]; endsequence
   sequence s_one; src_in.cmp_one[*4]; endsequence
   sequence s_two; src_in.cmp_two[*4]; endsequence
   property p_pin_set; s_pin ##0 c[7] |-> latch_drive.set_req; endproperty
   property p_two_set; s_two ##0 c[5] |-> latch_drive.set_req; endproperty
   property p_one_set; s_one ##0 c[4] |-> latch_drive.set_req; endproperty
   property p_pin_rst; s_pin ##0 c[3] |-> latch_drive.reset_req; endproperty
   property p_two_rst; s_two ##0 c[1] |-> latch_drive.reset_req; endproperty
   property p_no_set; c[7:4] == 4'h0 |-> !latch_drive.set_req; endproperty
   property p_no_rst; c[3:0] == 4'h0 |-> !latch_drive.reset_req; endproperty
   property p_clk_set;
      c == 8'h40 && $rose(latch_drive.set_req) |=> !latch_drive.set_req[*3];
   endproperty
   property p_clk_rst;
      c == 8'h04 && $rose(latch_drive.reset_req) |=> !latch_drive.reset_req[*3];
   endproperty
   a_pin_set: assert property (p_pin_set) else $error("pin set lost");
   a_two_set: assert property (p_two_set) else $error("cmp2 set lost");
   a_one_set: assert property (p_one_set) else $error("cmp1 set lost");
   a_pin_rst: assert property (p_pin_rst) else $error("pin reset lost");
   a_two_rst: assert property (p_two_rst) else $error("cmp2 rst lost");
   a_no_set: assert property (p_no_set) else $error("stray set");
   a_no_rst: assert property (p_no_rst) else $error("stray reset");
   a_clk_set: assert property (p_clk_set) else $error("set pulse");
   a_clk_rst: assert property (p_clk_rst) else $error("reset pulse");
endmodule : latch_src_asserts
bind latch_input_select latch_src_asserts chk_u (.clk(clk), .rst_n(rst_n),
   .av_req(av_req), .av_rsp(av_rsp), .src_in(src_in),
   .latch_drive(latch_drive));
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench for the latch input select block.
`include "latch_src_consts.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import latch_src_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   av_req_t      req = '0;
   av_rsp_t      rsp;
   src_in_t      src;
   latch_drive_t drv;
   logic [2:0]   lvl = 3'h0;
   logic [31:0]  q;
   int           fails = 0;
   int           num_checks = 0;
   int           n;
   always #2 clk = ~clk;
   latch_input_select dut_u (.clk(clk), .rst_n(rst_n), .av_req(req),
      .av_rsp(rsp), .src_in(src), .latch_drive(drv));
   latch_src_partner src_u (.clk(clk), .lvl(lvl), .src(src));
   task chk(string nm, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task bus(bit wr, logic [1:0] a, logic [31:0] d, logic [3:0] be);
      @(posedge clk);
      req <= '{a, !wr, wr, d, be};
      #1;
      while (rsp.waitrequest !== 1'b0) begin
         @(posedge clk);
         #1;
      end
      q = rsp.readdata;
      @(posedge clk);
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask : bus
   // Counts the cycles between two pulses of the chosen drive line.
   task period(bit r);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (drv[r] !== 1'b1);
      end
   endtask : period
   task print_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, 2'h0, 32'h0, 4'hF);
      chk("ctrl reset", q, 32'(`SRC_CTRL_RESET));
      bus(1, 2'h0, 32'hFFFF_FFA5, 4'hF);
      bus(1, 2'h0, 32'h0, 4'hE);
      bus(0, 2'h0, 32'h0, 4'hF);
      chk("ctrl", q, 32'hA5);
      bus(1, 2'h3, 32'hFF, 4'hF);
      bus(0, 2'h3, 32'h0, 4'hF);
      chk("unmapped", q, 32'h0);
      for (int e = 0; e < 8; e++) if (e % 4 != 2) begin
         bus(1, 2'h0, 32'h1 << e, 4'hF);
         for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            lvl <= 3'h1 << s;
            repeat (6) @(posedge clk);
            #1;
            n = (s == (e % 4 == 3 ? 2 : e % 4 == 1 ? 0 : 1));
            chk("drive", drv, {e > 3 && n, e < 4 && n});
         end
      end
      @(posedge clk);
      lvl <= 3'h0;
      for (int d = 0; d < 8; d++) begin
         bus(1, 2'h0, 32'h0, 4'hF);
         bus(1, 2'h1, 32'hF8 | d, 4'hF);
         bus(1, 2'h0, 32'h40, 4'hF);
         period(1);
         chk("set period", n, 4 << d);
      end
      bus(1, 2'h0, 32'h04, 4'hF);
      period(0);
      chk("reset period", n, 512);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
